/* src/crf_pkg.sv */
package crf_pkg;
  // register map over the bus (byte addresses)
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_XREG = 8'h04;
  localparam logic [7:0] ADDR_YREG = 8'h08;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h0C;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER = 8'h10;
  localparam logic [7:0] ADDR_PROCESSOR_STATUS_WORD = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_OPERAND = 8'h1C;
  localparam logic [7:0] ADDR_EFF_ADDR = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_VEC_DATA = 8'h28;
  // status word bit positions
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_B = 4;
  localparam int PSW_H = 3;
  localparam int PSW_I = 2;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] INT0_VECTOR = 16'hFFFC;
  localparam logic [15:0] INT1_VECTOR = 16'hFFFA;
  localparam logic [15:0] TCALL15_VECTOR = 16'hFFC0;
  localparam logic [15:0] PAGE_CALL_INSTRUCTION_BASE = 16'hFF00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] STACK_LOW_LIMIT = 8'hC0;
  localparam logic [15:0] PROG_SIZE = 16'h1000;
  localparam logic [8:0] DATA_SIZE = 9'h100;
  localparam logic [2:0] PAGE_CALL_INSTRUCTION_LEN = 3'h2;
  localparam logic [2:0] CALL_LEN = 3'h3;
  typedef enum logic [4:0] {
    CMD_NOP, CMD_ADD, CMD_SUB, CMD_LOAD_A, CMD_SHL, CMD_ROR,
    CMD_BIT_TEST, CMD_EI, CMD_DI, CMD_OVERFLOW_CLEAR_INSTRUCTION, CMD_SET_PAGE_INSTRUCTION, CMD_CLEAR_PAGE_INSTRUCTION,
    CMD_INCX, CMD_DECX, CMD_INCY, CMD_DECY, CMD_CMPX, CMD_TAX,
    CMD_TXA, CMD_CALL, CMD_PAGE_CALL_INSTRUCTION, CMD_TABLE_CALL_INSTRUCTION, CMD_BRK, CMD_IRQ0,
    CMD_IRQ1, CMD_RET, CMD_INTERRUPT_RETURN_INSTRUCTION, CMD_STEP, CMD_MOVW_YA
  } crf_cmd_t;
  typedef enum logic [1:0] {IDX_NONE, IDX_X, IDX_Y, IDX_DIRECT} crf_idx_t;
endpackage

/* src/crf_alu_if.sv */
`timescale 1ns/10ps
interface crf_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic sub;
  logic [7:0] res;
  logic carry;
  logic half;
  logic ovf;
  modport core (output a, output b, output sub, input res, input carry, input half, input ovf);
  modport alu (input a, input b, input sub, output res, output carry, output half, output ovf);
endinterface

/* src/crf_alu.sv */
`timescale 1ns/10ps
module crf_alu
  import crf_pkg::*;
(
  crf_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] bb;
  always_comb begin
    bb = bus.sub ? ~bus.b : bus.b;
    sum = {1'b0, bus.a} + {1'b0, bb} + {8'h00, bus.sub};
    lo = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, bus.sub};
  end
  assign bus.res = sum[7:0];
  // carry out for add, no-borrow for subtract
  assign bus.carry = sum[8];
  assign bus.half = lo[4];
  assign bus.ovf = (bus.a[7] == bb[7]) && (sum[7] != bus.a[7]);
endmodule // crf_alu

/* src/crf_core.sv */
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module crf_core
  import crf_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [15:0] PROG_ADDR,
  output logic [8:0] DATA_ADDR
);
  logic [7:0] acc;
  logic [7:0] xreg;
  logic [7:0] yreg;
  logic [7:0] stack_pointer;
  logic [7:0] program_counter_high;
  logic [7:0] program_counter_low;
  logic [7:0] processor_status_word;
  logic [7:0] operand;
  logic [8:0] eff_addr;
  logic [7:0] vec_data;
  logic [7:0] stack_mem [0:7];
  logic [3:0] sp_depth;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic vec_pending;
  logic wr_cmd;
  crf_cmd_t cmd;
  crf_idx_t idx_mode;
  logic [15:0] program_counter;
  logic [15:0] next_pc;
  logic [7:0] next_sp;
  logic [7:0] result;
  logic fire;
  crf_alu_if alu_bus ();

  crf_alu u_alu (
    .bus(alu_bus)
  );

  function automatic logic [7:0] wsel(input logic [7:0] a);
    return a & 8'hFC;
  endfunction

  assign program_counter = {program_counter_high, program_counter_low};
  assign alu_bus.a = (cmd == CMD_CMPX) ? xreg : acc;
  assign alu_bus.b = operand;
  assign alu_bus.sub = (cmd == CMD_SUB) || (cmd == CMD_CMPX);

  // ahb-lite slave, zero wait states
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (CLK_EN && HREADY) begin
      ph_valid <= HSEL && HTRANS[1];
      ph_write <= HWRITE;
      ph_addr <= wsel(HADDR[7:0]);
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign wr_cmd = CLK_EN && ph_valid && ph_write && (ph_addr == ADDR_CMD);
  assign fire = wr_cmd;
  assign cmd = crf_cmd_t'(HWDATA[4:0]);
  assign idx_mode = crf_idx_t'(HWDATA[9:8]);

  always_comb begin
    unique case (ph_addr)
      ADDR_ACC: HRDATA = {24'h0, acc};
      ADDR_XREG: HRDATA = {24'h0, xreg};
      ADDR_YREG: HRDATA = {16'h0, yreg, acc};
      ADDR_STACK_POINTER: HRDATA = {24'h0, stack_pointer};
      ADDR_PROGRAM_COUNTER: HRDATA = {16'h0, program_counter};
      ADDR_PROCESSOR_STATUS_WORD: HRDATA = {24'h0, processor_status_word};
      ADDR_OPERAND: HRDATA = {24'h0, operand};
      ADDR_EFF_ADDR: HRDATA = {23'h0, eff_addr};
      ADDR_STATUS: HRDATA = {27'h0, sp_depth, vec_pending};
      ADDR_VEC_DATA: HRDATA = {24'h0, vec_data};
      default: HRDATA = 32'h0;
    endcase
  end

  // program counter next value; 16-bit add wraps past FFFF
  always_comb begin
    next_pc = program_counter + 16'h0001;
    unique case (cmd)
      CMD_CALL: next_pc = program_counter + {13'h0, CALL_LEN};
      CMD_PAGE_CALL_INSTRUCTION: next_pc = PAGE_CALL_INSTRUCTION_BASE | {8'h00, operand};
      CMD_TABLE_CALL_INSTRUCTION: next_pc = TCALL15_VECTOR + {11'h0, ~operand[3:0], 1'b0};
      CMD_BRK: next_pc = TCALL15_VECTOR;
      CMD_IRQ0: next_pc = processor_status_word[PSW_I] ? INT0_VECTOR : program_counter + 16'h0001;
      CMD_IRQ1: next_pc = processor_status_word[PSW_I] ? INT1_VECTOR : program_counter + 16'h0001;
      default: next_pc = program_counter + 16'h0001;
    endcase
  end

  // stack pointer: save then decrement, increment then restore
  always_comb begin
    next_sp = stack_pointer;
    unique case (cmd)
      CMD_CALL, CMD_PAGE_CALL_INSTRUCTION, CMD_TABLE_CALL_INSTRUCTION: next_sp = stack_pointer - 8'h02;
      CMD_BRK: next_sp = stack_pointer - 8'h03;
      // a masked request is not served, so nothing is saved
      CMD_IRQ0, CMD_IRQ1: next_sp = processor_status_word[PSW_I] ? stack_pointer - 8'h03 : stack_pointer;
      CMD_RET: next_sp = stack_pointer + 8'h02;
      CMD_INTERRUPT_RETURN_INSTRUCTION: next_sp = stack_pointer + 8'h03;
      default: next_sp = stack_pointer;
    endcase
  end

  // stack pointer is never reset; software loads it
  always_ff @(posedge REF_CLK) begin
    if (CLK_EN) begin
      if (ph_valid && ph_write && ph_addr == ADDR_STACK_POINTER) begin
        stack_pointer <= HWDATA[7:0];
      end else if (fire) begin
        stack_pointer <= next_sp;
      end
    end
  end

  // small shadow of saved words, indexed by stack pointer low bits
  always_ff @(posedge REF_CLK) begin
    if (fire && (cmd == CMD_BRK || ((cmd == CMD_IRQ0 || cmd == CMD_IRQ1) && processor_status_word[PSW_I]))) begin
      stack_mem[stack_pointer[2:0]] <= processor_status_word;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sp_depth <= 4'h0;
    end else if (fire) begin
      if (next_sp < stack_pointer) begin
        sp_depth <= sp_depth + 4'h1;
      end else if (next_sp > stack_pointer && sp_depth != 4'h0) begin
        sp_depth <= sp_depth - 4'h1;
      end
    end
  end

  // reset vector fetch: commands do not advance the counter from FFFE until vector data is written
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      program_counter_high <= RESET_VECTOR[15:8];
      program_counter_low <= RESET_VECTOR[7:0];
      vec_pending <= 1'b1;
      vec_data <= 8'h00;
    end else if (CLK_EN) begin
      if (ph_valid && ph_write && ph_addr == ADDR_VEC_DATA) begin
        vec_data <= HWDATA[7:0];
        if (vec_pending) begin
          program_counter_high <= HWDATA[15:8];
          program_counter_low <= HWDATA[7:0];
          vec_pending <= 1'b0;
        end
      end else if (ph_valid && ph_write && ph_addr == ADDR_PROGRAM_COUNTER) begin
        program_counter_high <= HWDATA[15:8];
        program_counter_low <= HWDATA[7:0];
      end else if (fire && !vec_pending) begin
        program_counter_high <= next_pc[15:8];
        program_counter_low <= next_pc[7:0];
      end
    end
  end

  always_comb begin
    result = acc;
    unique case (cmd)
      CMD_ADD, CMD_SUB: result = alu_bus.res;
      CMD_LOAD_A: result = operand;
      CMD_SHL: result = {acc[6:0], 1'b0};
      CMD_ROR: result = {processor_status_word[PSW_C], acc[7:1]};
      CMD_TXA: result = xreg;
      default: result = acc;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      acc <= 8'h00;
      yreg <= 8'h00;
    end else if (CLK_EN) begin
      if (ph_valid && ph_write && ph_addr == ADDR_ACC) begin
        acc <= HWDATA[7:0];
      end else if (ph_valid && ph_write && ph_addr == ADDR_YREG) begin
        yreg <= HWDATA[15:8];
        acc <= HWDATA[7:0];
      end else if (fire) begin
        acc <= result;
        if (cmd == CMD_INCY) yreg <= yreg + 8'h01;
        if (cmd == CMD_DECY) yreg <= yreg - 8'h01;
        if (cmd == CMD_MOVW_YA) yreg <= operand;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      xreg <= 8'h00;
      operand <= 8'h00;
    end else if (CLK_EN) begin
      if (ph_valid && ph_write && ph_addr == ADDR_XREG) begin
        xreg <= HWDATA[7:0];
      end else if (ph_valid && ph_write && ph_addr == ADDR_OPERAND) begin
        operand <= HWDATA[7:0];
      end else if (fire) begin
        unique case (cmd)
          CMD_INCX: xreg <= xreg + 8'h01;
          CMD_DECX: xreg <= xreg - 8'h01;
          CMD_TAX: xreg <= acc;
          default: xreg <= xreg;
        endcase
      end
    end
  end

  // effective data address for the instruction's memory operand
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      eff_addr <= 9'h000;
    end else if (fire) begin
      unique case (idx_mode)
        IDX_X: eff_addr <= {processor_status_word[PSW_G], operand + xreg};
        IDX_Y: eff_addr <= {processor_status_word[PSW_G], operand + yreg};
        IDX_DIRECT: eff_addr <= {processor_status_word[PSW_G], operand};
        IDX_NONE: eff_addr <= {STACK_PAGE[0], stack_pointer};
      endcase
    end
  end
  assign PROG_ADDR = program_counter & (PROG_SIZE - 16'h0001);
  assign DATA_ADDR = eff_addr;

  // status word flags
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      processor_status_word <= PSW_RESET;
    end else if (CLK_EN) begin
      if (ph_valid && ph_write && ph_addr == ADDR_PROCESSOR_STATUS_WORD) begin
        processor_status_word <= HWDATA[7:0];
      end else if (fire) begin
        unique case (cmd)
          CMD_ADD, CMD_SUB: begin
            processor_status_word[PSW_C] <= alu_bus.carry;
            processor_status_word[PSW_V] <= processor_status_word[PSW_V] | alu_bus.ovf;
            processor_status_word[PSW_H] <= processor_status_word[PSW_H] | alu_bus.half;
            processor_status_word[PSW_Z] <= (alu_bus.res == 8'h00);
            processor_status_word[PSW_N] <= alu_bus.res[7];
          end
          CMD_CMPX: begin
            processor_status_word[PSW_C] <= alu_bus.carry;
            processor_status_word[PSW_Z] <= (alu_bus.res == 8'h00);
            processor_status_word[PSW_N] <= alu_bus.res[7];
          end
          CMD_LOAD_A, CMD_TXA: begin
            processor_status_word[PSW_Z] <= (result == 8'h00);
            processor_status_word[PSW_N] <= result[7];
          end
          CMD_SHL, CMD_ROR: begin
            processor_status_word[PSW_C] <= (cmd == CMD_SHL) ? acc[7] : acc[0];
            processor_status_word[PSW_Z] <= (result == 8'h00);
            processor_status_word[PSW_N] <= result[7];
          end
          CMD_BIT_TEST: begin
            processor_status_word[PSW_N] <= operand[7];
            processor_status_word[PSW_V] <= operand[6];
            processor_status_word[PSW_Z] <= ((acc & operand) == 8'h00);
          end
          CMD_EI: processor_status_word[PSW_I] <= 1'b1;
          CMD_DI: processor_status_word[PSW_I] <= 1'b0;
          CMD_OVERFLOW_CLEAR_INSTRUCTION: begin
            processor_status_word[PSW_V] <= 1'b0;
            processor_status_word[PSW_H] <= 1'b0;
          end
          CMD_SET_PAGE_INSTRUCTION: processor_status_word[PSW_G] <= 1'b1;
          CMD_CLEAR_PAGE_INSTRUCTION: processor_status_word[PSW_G] <= 1'b0;
          CMD_BRK: processor_status_word[PSW_B] <= 1'b1;
          CMD_IRQ0, CMD_IRQ1: begin
            // masked requests are not served
            if (processor_status_word[PSW_I]) processor_status_word[PSW_I] <= 1'b0;
          end
          CMD_INTERRUPT_RETURN_INSTRUCTION: processor_status_word <= stack_mem[next_sp[2:0]];
          default: processor_status_word <= processor_status_word;
        endcase
      end
    end
  end
endmodule // crf_core

/* verif/crf_core_monitor.sv */
`timescale 1ns/10ps
module crf_core_monitor
  import crf_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [15:0] PROG_ADDR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic dv;
  logic dw;
  logic [7:0] da;
  logic vec_done;
  logic touched;
  // data-phase tracker of the bus
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      dv <= 1'b0;
      dw <= 1'b0;
      da <= 8'h00;
      vec_done <= 1'b0;
      touched <= 1'b0;
    end else if (CLK_EN) begin
      dv <= HSEL && HTRANS[1] && HREADY;
      dw <= HWRITE;
      da <= HADDR[7:0];
      if (dv && dw && da == ADDR_VEC_DATA) begin
        vec_done <= 1'b1;
      end
      if (dv && dw && (da == ADDR_CMD || da == ADDR_PROCESSOR_STATUS_WORD)) begin
        touched <= 1'b1;
      end
    end
  end
  sequence wr_s(ad);
    dv && dw && da == ad && CLK_EN;
  endsequence
  sequence rd_s(ad);
    dv && !dw && da == ad;
  endsequence
  ready_high_a: assert property (HREADYOUT) else $error("wait state seen");
  resp_okay_a: assert property (!HRESP) else $error("error response seen");
  reset_vec_a: assert property ($rose(NRST) |-> PROG_ADDR == 16'h0FFE)
    else $error("start address wrong after reset");
  prog_range_a: assert property (PROG_ADDR < PROG_SIZE) else $error("program address beyond 4K");
  unmapped_zero_a: assert property (dv && !dw && da > ADDR_VEC_DATA |-> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  acc_back_a: assert property (wr_s(ADDR_ACC) ##1 rd_s(ADDR_ACC) |-> HRDATA[7:0] == $past(HWDATA[7:0]))
    else $error("accumulator readback wrong");
  stack_back_a: assert property (wr_s(ADDR_STACK_POINTER) ##1 rd_s(ADDR_STACK_POINTER)
    |-> HRDATA[7:0] == $past(HWDATA[7:0])) else $error("stack pointer readback wrong");
  vec_load_a: assert property (wr_s(ADDR_VEC_DATA) ##0 !vec_done
    |=> PROG_ADDR == ($past(HWDATA[15:0]) & 16'h0FFF)) else $error("vector not loaded");
  flags_reset_a: assert property (rd_s(ADDR_PROCESSOR_STATUS_WORD) ##0 !touched |-> HRDATA[7:0] == PSW_RESET)
    else $error("status word not clear after reset");
endmodule // crf_core_monitor

bind crf_core crf_core_monitor mon_u (.REF_CLK, .NRST, .CLK_EN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .PROG_ADDR);

/* verif/crf_prog_mem.sv */
`timescale 1ns/10ps
module crf_prog_mem
  import crf_pkg::*;
#(
  parameter logic [15:0] BOOT = 16'h8000
)(
  input wire logic [15:0] PROG_ADDR,
  output logic [15:0] VEC_WORD
);
  logic [7:0] rom [0:4095];
  initial begin
    // filler code also occupies unused vector locations
    foreach (rom[i]) rom[i] = 8'(i) ^ 8'hA5;
    rom[12'hFFE] = BOOT[7:0];
    rom[12'hFFF] = BOOT[15:8];
  end
  // only 4K is built, upper address bits fold away and the top wraps
  assign VEC_WORD = {rom[PROG_ADDR[11:0] + 12'h1], rom[PROG_ADDR[11:0]]};
endmodule // crf_prog_mem

/* verif/test_cpu_core_registers_flags.sv */
`timescale 1ns/10ps
module test_cpu_core_registers_flags;
  import crf_pkg::*;
  localparam logic [15:0] BOOT = 16'hF123;
  localparam logic [7:0] FLG = ADDR_PROCESSOR_STATUS_WORD;
  localparam logic [7:0] SPR = ADDR_STACK_POINTER;
  localparam logic [7:0] PCR = ADDR_PROGRAM_COUNTER;
  logic REF_CLK, NRST, CLK_EN, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [15:0] PROG_ADDR, VEC_WORD;
  logic [8:0] DATA_ADDR;
  logic [7:0] a, b, p;
  int mismatches, samples_checked;
  crf_cmd_t fc[5] = '{CMD_EI, CMD_DI, CMD_SET_PAGE_INSTRUCTION, CMD_CLEAR_PAGE_INSTRUCTION, CMD_OVERFLOW_CLEAR_INSTRUCTION};
  logic [7:0] fp[5] = '{8'h00, 8'h04, 8'h00, 8'h20, 8'h48};
  logic [7:0] fq[5] = '{8'h04, 8'h00, 8'h20, 8'h00, 8'h00};
  logic [7:0] ca[4] = '{8'h7F, 8'hFF, 8'h80, 8'h0F};
  logic [7:0] cb[4] = '{8'h01, 8'h01, 8'h80, 8'h01};
  crf_core dut_u (.REF_CLK, .NRST, .CLK_EN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PROG_ADDR, .DATA_ADDR);
  crf_prog_mem #(.BOOT(BOOT)) mem_u (.PROG_ADDR, .VEC_WORD);
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  function automatic logic [7:0] add_psw(input logic [7:0] f, x, y);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, y};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    f[PSW_C] = s[8];
    f[PSW_Z] = s[7:0] == 8'h00;
    f[PSW_N] = s[7];
    f[PSW_H] = f[PSW_H] | h[4];
    f[PSW_V] = f[PSW_V] | (x[7] == y[7] && s[7] != x[7]);
    return f;
  endfunction
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
  endtask
  // rb: a read of the same register follows the write back to back
  task automatic bus(input logic w, input logic rb, input logic [7:0] ad, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, ad};
    HWRITE <= w;
    wait_rdy();
    HWDATA <= d;
    HWRITE <= 1'b0;
    if (!rb) HTRANS <= 2'h0;
    wait_rdy();
    rd = HRDATA;
    if (rb) begin
      HTRANS <= 2'h0;
      wait_rdy();
      rd = HRDATA;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, 1'b0, ad, d);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, 1'b0, ad, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmd(input crf_cmd_t c, input crf_idx_t x);
    wr(ADDR_CMD, {22'h0, x, 3'h0, c});
  endtask
  initial begin
    NRST = 1'b0;
    CLK_EN = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(40745));
    repeat (12) @(posedge REF_CLK);
    NRST <= 1'b1;
    rchk(PCR, {16'h0, RESET_VECTOR});
    rchk(FLG, 32'h0);
    chk({16'h0, PROG_ADDR}, 32'h0FFE);
    wr(ADDR_VEC_DATA, {16'h0, VEC_WORD});
    rchk(PCR, {16'h0, BOOT});
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(FLG, {24'h0, fp[k]});
      cmd(fc[k], IDX_NONE);
      rchk(FLG, {24'h0, fq[k]});
    end
    wr(ADDR_XREG, 32'h10);
    wr(ADDR_YREG, 32'h2021);
    rchk(ADDR_ACC, 32'h21);
    wr(ADDR_OPERAND, 32'h35);
    cmd(CMD_NOP, IDX_X);
    rchk(ADDR_EFF_ADDR, 32'h45);
    chk({23'h0, DATA_ADDR}, 32'h45);
    cmd(CMD_NOP, IDX_Y);
    rchk(ADDR_EFF_ADDR, 32'h55);
    cmd(CMD_SET_PAGE_INSTRUCTION, IDX_NONE);
    cmd(CMD_NOP, IDX_DIRECT);
    rchk(ADDR_EFF_ADDR, 32'h135);
    cmd(CMD_CLEAR_PAGE_INSTRUCTION, IDX_NONE);
    cmd(CMD_NOP, IDX_DIRECT);
    rchk(ADDR_EFF_ADDR, 32'h35);
    cmd(CMD_INCX, IDX_NONE);
    cmd(CMD_DECY, IDX_NONE);
    rchk(ADDR_XREG, 32'h11);
    rchk(ADDR_YREG, 32'h1F21);
    for (int i = 0; i < 24; i++) begin
      a = i < 4 ? ca[i] : 8'($urandom);
      b = i < 4 ? cb[i] : 8'($urandom);
      p = 8'($urandom) & 8'hFE;
      wr(FLG, {24'h0, p});
      bus(1'b1, 1'b1, ADDR_ACC, {24'h0, a});
      chk(rd, {24'h0, a});
      wr(ADDR_OPERAND, {24'h0, b});
      cmd(CMD_ADD, IDX_NONE);
      rchk(ADDR_ACC, {24'h0, a + b});
      rchk(FLG, {24'h0, add_psw(p, a, b)});
      wr(FLG, 32'h0);
      cmd(CMD_BIT_TEST, IDX_NONE);
      bus(1'b0, 1'b0, FLG, 32'h0);
      chk({30'h0, rd[7:6]}, {30'h0, b[7:6]});
    end
    bus(1'b1, 1'b1, SPR, 32'hFF);
    chk(rd, 32'hFF);
    wr(FLG, 32'h0);
    cmd(CMD_CALL, IDX_NONE);
    rchk(SPR, 32'hFD);
    wr(ADDR_OPERAND, 32'h35);
    cmd(CMD_PAGE_CALL_INSTRUCTION, IDX_NONE);
    rchk(SPR, 32'hFB);
    rchk(PCR, 32'hFF35);
    cmd(CMD_RET, IDX_NONE);
    rchk(SPR, 32'hFD);
    for (int j = 0; j < 2; j++) begin
      wr(FLG, 32'h04);
      cmd(j ? CMD_IRQ1 : CMD_IRQ0, IDX_NONE);
      rchk(SPR, 32'hFA);
      rchk(PCR, j ? 32'hFFFA : 32'hFFFC);
      rchk(FLG, 32'h0);
      cmd(CMD_INTERRUPT_RETURN_INSTRUCTION, IDX_NONE);
      rchk(SPR, 32'hFD);
      rchk(FLG, 32'h04);
    end
    wr(FLG, 32'h0);
    cmd(CMD_IRQ0, IDX_NONE);
    rchk(SPR, 32'hFD);
    cmd(CMD_BRK, IDX_NONE);
    rchk(SPR, 32'hFA);
    rchk(FLG, 32'h10);
    for (int n = 0; n < 16; n += 15) begin
      wr(ADDR_OPERAND, 32'(n));
      cmd(CMD_TABLE_CALL_INSTRUCTION, IDX_NONE);
      rchk(PCR, 32'hFFC0 + 32'(2 * (15 - n)));
      chk({16'h0, PROG_ADDR}, 32'h0FC0 + 32'(2 * (15 - n)));
    end
    wr(PCR, 32'hFFFF);
    cmd(CMD_STEP, IDX_NONE);
    rchk(PCR, 32'h0);
    stop_test();
  end
endmodule // test_cpu_core_registers_flags
